// File: hw/ep_ctl.sv
// Endpoint abort (device role) and transfer scheduler with buffer selector (host role).
// Assumes link-side strobes are generated on REF_CLK by the packet engine.
`timescale 1ns/1ps
`default_nettype none
module ep_ctl (
	// Clock and reset
	input  wire logic                        REF_CLK,
	input  wire logic                        RST,
	// Register port
	input  wire logic [7:0]                  REG_ADDR,
	input  wire logic [31:0]                 REG_WDATA,
	input  wire logic                        REG_WR,
	input  wire logic                        REG_RD,
	output logic      [31:0]                 REG_RDATA,
	output logic                             IRQ,
	// Device-role link side
	input  wire logic                        DEV_TXN_START,
	input  wire logic [ep_ctl_pkg::EP_W-1:0] DEV_TXN_EP,
	input  wire logic                        DEV_TXN_DONE,
	output logic                             DEV_RESP_VALID,
	output logic      [1:0]                  DEV_RESP_CODE,
	// Host-role link side
	output logic                             HOST_TXN_REQ,
	output logic      [ep_ctl_pkg::EP_W-1:0] HOST_TXN_EP,
	output logic                             HOST_TXN_INTR,
	output logic                             HOST_BUF_SEL,
	output logic                             HOST_FETCH_HALF,
	input  wire logic                        HOST_TXN_DONE
);
	localparam int N = ep_ctl_pkg::NUM_EP;

	// ************************
	// Registers
	// ************************
	logic [31:0]                  ctrl;
	logic [N-1:0]                 endpoint_abort_mask;
	logic [N-1:0]                 armed;
	logic [N-1:0]                 abort_hit;
	logic [31:0]                  int_cfg;
	logic [1:0]                   buffer_software_pending;
	logic [ep_ctl_pkg::IRQ_W-1:0] irq_stat;
	logic [ep_ctl_pkg::IRQ_W-1:0] irq_en;
	logic [ep_ctl_pkg::EP_W-1:0]  dev_ep;
	logic [ep_ctl_pkg::EP_W-1:0]  sw_ep;
	ep_ctl_pkg::host_state_e      host_state;
	logic                         dev_busy, buf_sel, sw_req, int_due;

	logic                         host_mode, double_buf, int_enable, us_tick, ivl_fire, dev_aborted;
	logic                         wr_abort, wr_arm, wr_hit, wr_start, wr_pend, wr_clr;
	logic                         launch_sw, launch_int, host_done;
	logic [ep_ctl_pkg::IRQ_W-1:0] irq_set;

	assign host_mode  = ctrl[ep_ctl_pkg::CTRL_HOST];
	assign double_buf = ctrl[ep_ctl_pkg::CTRL_DOUBLE];
	assign int_enable = int_cfg[ep_ctl_pkg::INT_EN_BIT] && host_mode;
	assign wr_abort   = REG_WR && (REG_ADDR == ep_ctl_pkg::OFS_ABORT);
	assign wr_arm     = REG_WR && (REG_ADDR == ep_ctl_pkg::OFS_ARM);
	assign wr_hit     = REG_WR && (REG_ADDR == ep_ctl_pkg::OFS_ABORT_HIT);
	assign wr_start   = REG_WR && (REG_ADDR == ep_ctl_pkg::OFS_START);
	assign wr_pend    = REG_WR && (REG_ADDR == ep_ctl_pkg::OFS_PENDING);
	assign wr_clr     = REG_WR && (REG_ADDR == ep_ctl_pkg::OFS_IRQ_CLR);

	// ************************
	// Interval timing
	// ************************
	ep_interval_timer #(.WIDTH(8)) u_us_prescale (
		.clk     (REF_CLK),
		.rst     (RST),
		.enable  (int_enable),
		.tick_in (1'b1),
		.period  (ep_ctl_pkg::US_RELOAD),
		.fire    (us_tick)
	);

	// Poll interval in microseconds
	ep_interval_timer #(.WIDTH(16)) u_poll_interval (
		.clk     (REF_CLK),
		.rst     (RST),
		.enable  (int_enable),
		.tick_in (us_tick),
		.period  (int_cfg[ep_ctl_pkg::INT_IVL_LSB +: 16]),
		.fire    (ivl_fire)
	);

	// ************************
	// Software registers
	// ************************
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			ctrl    <= ep_ctl_pkg::RST_WORD;
			int_cfg <= ep_ctl_pkg::RST_WORD;
			irq_en  <= '0;
		end else if (REG_WR) begin
			if (REG_ADDR == ep_ctl_pkg::OFS_CTRL) ctrl <= {30'h0000_0000, REG_WDATA[1:0]};
			if (REG_ADDR == ep_ctl_pkg::OFS_INT_CFG) begin
				int_cfg <= {REG_WDATA[31:16], 7'h00, REG_WDATA[8], 4'h0, REG_WDATA[3:0]};
			end
			if (REG_ADDR == ep_ctl_pkg::OFS_IRQ_EN) irq_en <= REG_WDATA[ep_ctl_pkg::IRQ_W-1:0];
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			endpoint_abort_mask <= '0;
		end else if (wr_abort) begin
			endpoint_abort_mask <= REG_WDATA[N-1:0];
		end
	end

	// ************************
	// Device role: abort
	// ************************
	assign dev_aborted = endpoint_abort_mask[DEV_TXN_EP];

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			armed <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				if (endpoint_abort_mask[i]) armed[i] <= 1'b0; // R1
				else if (wr_arm && REG_WDATA[i]) armed[i] <= 1'b1;
				else if (DEV_TXN_DONE && dev_busy && (dev_ep == ep_ctl_pkg::EP_W'(i))) armed[i] <= 1'b0;
			end
		end
	end

	// Abort hit: set wins over clear
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			abort_hit <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				if (DEV_TXN_START && !host_mode && dev_aborted && (DEV_TXN_EP == ep_ctl_pkg::EP_W'(i))) begin
					abort_hit[i] <= 1'b1;
				end else if (wr_hit && REG_WDATA[i]) begin
					abort_hit[i] <= 1'b0;
				end
			end
		end
	end

	// Answer per transaction; aborted or unarmed endpoint is refused
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			DEV_RESP_VALID <= 1'b0;
			DEV_RESP_CODE  <= ep_ctl_pkg::RESP_NAK;
			dev_busy       <= 1'b0;
			dev_ep         <= '0;
		end else begin
			DEV_RESP_VALID <= DEV_TXN_START && !host_mode;
			if (DEV_TXN_START && !host_mode) begin
				if (dev_aborted || !armed[DEV_TXN_EP]) begin
					DEV_RESP_CODE <= ep_ctl_pkg::RESP_NAK; // R2
					dev_busy      <= 1'b0;                 // R2
				end else begin
					DEV_RESP_CODE <= ep_ctl_pkg::RESP_ACK;
					dev_busy      <= 1'b1;
					dev_ep        <= DEV_TXN_EP;
				end
			end else if (DEV_TXN_DONE || endpoint_abort_mask[dev_ep]) begin
				dev_busy <= 1'b0; // R1
			end
		end
	end

	// ************************
	// Host role: scheduler
	// ************************
	assign launch_sw  = (host_state == ep_ctl_pkg::H_IDLE) && sw_req;
	assign launch_int = (host_state == ep_ctl_pkg::H_IDLE) && !sw_req && int_due;
	assign host_done  = HOST_TXN_DONE && (host_state != ep_ctl_pkg::H_IDLE);

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			sw_req <= 1'b0;
			sw_ep  <= '0;
		end else if (wr_start && host_mode) begin
			sw_req <= 1'b1; // R4
			sw_ep  <= REG_WDATA[ep_ctl_pkg::EP_W-1:0];
		end else if (launch_sw) begin
			sw_req <= 1'b0;
		end
	end

	// Poll due: new interval wins over launch
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) int_due <= 1'b0;
		else if (ivl_fire) int_due <= 1'b1; // R5
		else if (launch_int || !int_enable) int_due <= 1'b0;
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			host_state    <= ep_ctl_pkg::H_IDLE;
			HOST_TXN_REQ  <= 1'b0;
			HOST_TXN_EP   <= '0;
			HOST_TXN_INTR <= 1'b0;
		end else begin
			HOST_TXN_REQ <= launch_sw || launch_int;
			unique case (host_state)
				ep_ctl_pkg::H_IDLE: begin
					if (launch_sw) begin
						host_state    <= ep_ctl_pkg::H_SW;
						HOST_TXN_EP   <= sw_ep;
						HOST_TXN_INTR <= 1'b0;
					end else if (launch_int) begin
						host_state    <= ep_ctl_pkg::H_INT; // R5
						HOST_TXN_EP   <= int_cfg[ep_ctl_pkg::EP_W-1:0];
						HOST_TXN_INTR <= 1'b1;
					end
				end
				ep_ctl_pkg::H_SW,
				ep_ctl_pkg::H_INT: begin
					if (HOST_TXN_DONE || !host_mode) begin
						host_state <= ep_ctl_pkg::H_IDLE;
					end
				end
				default: begin
					host_state <= ep_ctl_pkg::H_IDLE;
				end
			endcase
		end
	end

	// Selector: toggles on double-buffered software transfers only, cleared only by RST
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			buf_sel <= 1'b0;
		end else if (host_done && (host_state == ep_ctl_pkg::H_SW) && double_buf) begin
			buf_sel <= ~buf_sel; // R9
		end
	end

	assign HOST_BUF_SEL    = buf_sel;                                                          // R7
	assign HOST_FETCH_HALF = double_buf && !HOST_TXN_INTR ? buf_sel : 1'b0; // R6 R10

	// Pending half as selected at completion; set wins over clear
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			buffer_software_pending <= 2'h0;
		end else begin
			for (int h = 0; h < 2; h++) begin
				if (host_done && (buf_sel == h[0])) buffer_software_pending[h] <= 1'b1; // R7
				else if (wr_pend && REG_WDATA[h]) buffer_software_pending[h] <= 1'b0;
			end
		end
	end

	// ************************
	// Interrupts
	// ************************
	always_comb begin
		irq_set                           = '0;
		irq_set[ep_ctl_pkg::IRQ_ABORT]    = DEV_TXN_START && !host_mode && dev_aborted;
		irq_set[ep_ctl_pkg::IRQ_DEV_DONE] = DEV_TXN_DONE && dev_busy;
		irq_set[ep_ctl_pkg::IRQ_SW_DONE]  = host_done && (host_state == ep_ctl_pkg::H_SW);
		irq_set[ep_ctl_pkg::IRQ_INT_DONE] = host_done && (host_state == ep_ctl_pkg::H_INT);
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			irq_stat <= '0;
		end else begin
			irq_stat <= irq_set | (irq_stat & ~(wr_clr ? REG_WDATA[ep_ctl_pkg::IRQ_W-1:0] : '0));
		end
	end

	assign IRQ = |(irq_stat & irq_en);

	// ************************
	// Read port
	// ************************
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			REG_RDATA <= ep_ctl_pkg::RST_WORD;
		end else if (REG_RD) begin
			unique case (REG_ADDR)
				ep_ctl_pkg::OFS_CTRL:      REG_RDATA <= ctrl;
				ep_ctl_pkg::OFS_ABORT:     REG_RDATA <= 32'(endpoint_abort_mask);
				ep_ctl_pkg::OFS_ARM:       REG_RDATA <= 32'(armed);
				ep_ctl_pkg::OFS_ABORT_HIT: REG_RDATA <= 32'(abort_hit);
				ep_ctl_pkg::OFS_START:     REG_RDATA <= {29'h0, sw_req, host_state};
				ep_ctl_pkg::OFS_INT_CFG:   REG_RDATA <= int_cfg;
				ep_ctl_pkg::OFS_PENDING:   REG_RDATA <= {29'h0, buf_sel, buffer_software_pending};
				ep_ctl_pkg::OFS_IRQ_STAT:  REG_RDATA <= 32'(irq_stat);
				ep_ctl_pkg::OFS_IRQ_EN:    REG_RDATA <= 32'(irq_en);
				default:                   REG_RDATA <= ep_ctl_pkg::RST_WORD;
			endcase
		end else begin
			REG_RDATA <= ep_ctl_pkg::RST_WORD;
		end
	end
endmodule
`default_nettype wire

// File: hw/ep_ctl_pkg.sv
// Constants for the endpoint abort and host buffer selector block.
// Assumes one 250 MHz clock and a same-clock register port.
//
// Functional notes
// R1: Abort mask bit cancels endpoint's pending transactions.
// R2: Aborted-endpoint transaction never locks other endpoints.
// R3: Old-revision software leaves abort mask unused.
// R4: Host runs software-started and periodic interrupt transfers.
// R5: Interrupt endpoint polled each elapsed interval automatically.
// R6: Interrupt transfers use one buffer, no alternation.
// R7: Selector not reset before interrupt transfer.
// R8: Software ignores pending-half register for interrupt endpoints.
// R9: Selector toggles only under double buffering.
// R10: Single-buffered fetch disregards the buffer selector.
package ep_ctl_pkg;
	// ************************
	// Sizes and timing
	// ************************
	localparam int          NUM_EP        = 16;
	localparam int          EP_W          = 4;
	localparam int          CLK_PERIOD_PS = 4000;
	localparam int          US_PS         = 1000000;
	localparam int          US_CYCLES     = (US_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [7:0]  US_RELOAD     = 8'(US_CYCLES);

	// ************************
	// Register offsets
	// ************************
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_ABORT     = 8'h04;
	localparam logic [7:0]  OFS_ARM       = 8'h08;
	localparam logic [7:0]  OFS_ABORT_HIT = 8'h0C;
	localparam logic [7:0]  OFS_START     = 8'h10;
	localparam logic [7:0]  OFS_INT_CFG   = 8'h14;
	localparam logic [7:0]  OFS_PENDING   = 8'h18;
	localparam logic [7:0]  OFS_IRQ_STAT  = 8'h1C;
	localparam logic [7:0]  OFS_IRQ_CLR   = 8'h20;
	localparam logic [7:0]  OFS_IRQ_EN    = 8'h24;

	// ************************
	// Fields
	// ************************
	localparam int          CTRL_HOST     = 0;
	localparam int          CTRL_DOUBLE   = 1;
	localparam int          INT_EN_BIT    = 8;
	localparam int          INT_IVL_LSB   = 16;
	localparam int          IRQ_ABORT     = 0;
	localparam int          IRQ_DEV_DONE  = 1;
	localparam int          IRQ_SW_DONE   = 2;
	localparam int          IRQ_INT_DONE  = 3;
	localparam int          IRQ_W         = 4;

	// ************************
	// Reset values and codes
	// ************************
	localparam logic [31:0] RST_WORD      = 32'h0000_0000;
	localparam logic [1:0]  RESP_ACK      = 2'h0;
	localparam logic [1:0]  RESP_NAK      = 2'h1;

	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_SW   = 2'b01,
		H_INT  = 2'b10
	} host_state_e;
endpackage

// File: hw/ep_interval_timer.sv
// Reloading down-counter that pulses once per programmed period.
// Assumes tick_in and period come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module ep_interval_timer #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Control
	input  wire logic             enable,
	input  wire logic             tick_in,
	input  wire logic [WIDTH-1:0] period,
	// Event
	output logic                  fire
);
	logic [WIDTH-1:0] count;

	if (WIDTH < 2) begin : g_width_check
		$error("WIDTH too small");
	end

	assign fire = enable && tick_in && (count <= 1);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count <= '0;
		end else if (!enable) begin
			count <= '0;
		end else if (tick_in) begin
			if (count <= 1) begin
				count <= period;
			end else begin
				count <= count - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// File: sim/ep_ctl_assertions.sv
// Port-level checker for ep_ctl.
// Assumes binding onto ep_ctl; keeps a shadow of the software state.
`timescale 1ns/1ps
`default_nettype none
module ep_ctl_assertions (
	// Clock and reset
	input wire logic				REF_CLK,
	input wire logic				RST,
	// Register port
	input wire logic [7:0]				REG_ADDR,
	input wire logic [31:0]				REG_WDATA,
	input wire logic				REG_WR,
	input wire logic				REG_RD,
	input wire logic [31:0]				REG_RDATA,
	// Device link
	input wire logic				DEV_TXN_START,
	input wire logic [ep_ctl_pkg::EP_W-1:0]	DEV_TXN_EP,
	input wire logic				DEV_TXN_DONE,
	input wire logic				DEV_RESP_VALID,
	input wire logic [1:0]				DEV_RESP_CODE,
	// Host link
	input wire logic				HOST_TXN_REQ,
	input wire logic [ep_ctl_pkg::EP_W-1:0]	HOST_TXN_EP,
	input wire logic				HOST_TXN_INTR,
	input wire logic				HOST_BUF_SEL,
	input wire logic				HOST_FETCH_HALF,
	input wire logic				HOST_TXN_DONE
);
	// ****************
	// Shadow state
	// ****************
	logic		host, dbl, ien, busy;
	logic [15:0]	mask, armed, next_armed, ivl;
	logic [3:0]	sep, lack;
	int		quiet, lim;
	logic		w_ctl, w_cfg, w_abt, w_arm;

	assign w_ctl = REG_WR && REG_ADDR == ep_ctl_pkg::OFS_CTRL;
	assign w_cfg = REG_WR && REG_ADDR == ep_ctl_pkg::OFS_INT_CFG;
	assign w_abt = REG_WR && REG_ADDR == ep_ctl_pkg::OFS_ABORT;
	assign w_arm = REG_WR && REG_ADDR == ep_ctl_pkg::OFS_ARM;
	assign lim = (ivl == 16'h0 ? 1 : int'(ivl)) * ep_ctl_pkg::US_CYCLES + 8;

	always_comb begin
		next_armed = armed;
		if (w_arm) next_armed = armed | (REG_WDATA[15:0] & ~mask);
		if (w_abt) next_armed = next_armed & ~REG_WDATA[15:0];
		if (DEV_TXN_DONE) next_armed[lack] = 1'h0;
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			{host, dbl, ien, busy} <= '0;
			{mask, armed, ivl, sep, lack} <= '0;
			quiet <= 0;
		end else begin
			if (w_ctl) {dbl, host} <= REG_WDATA[1:0];
			if (w_cfg) {ivl, ien} <= {REG_WDATA[31:16], REG_WDATA[8]};
			if (w_abt) mask <= REG_WDATA[15:0];
			armed <= next_armed;
			if (DEV_TXN_START) sep <= DEV_TXN_EP;
			if (DEV_RESP_VALID && DEV_RESP_CODE == ep_ctl_pkg::RESP_ACK) lack <= sep;
			busy <= HOST_TXN_REQ || (busy && !HOST_TXN_DONE);
			quiet <= (!ien || !host || busy || HOST_TXN_REQ) ? 0 : quiet + 1;
		end
	end

	// ****************
	// Properties
	// ****************
	default clocking dc @(posedge REF_CLK);
	endclocking
	default disable iff (RST);

	sequence s_dev_start;
		DEV_TXN_START && !host;
	endsequence
	sequence s_sw_write;
		REG_WR && REG_ADDR == ep_ctl_pkg::OFS_START && host && !busy && !ien;
	endsequence
	property p_sw_launch;
		s_sw_write |-> ##2 HOST_TXN_REQ && !HOST_TXN_INTR && HOST_TXN_EP == $past(REG_WDATA[3:0], 2);
	endproperty

	a_resp_latency: assert property (s_dev_start |=> DEV_RESP_VALID)
		else $error("device response missing");
	a_resp_cause: assert property (DEV_RESP_VALID |-> $past(DEV_TXN_START) && !$past(host))
		else $error("device response without start");
	a_abort_nak: assert property (s_dev_start ##0 mask[DEV_TXN_EP] |=> DEV_RESP_CODE == ep_ctl_pkg::RESP_NAK)
		else $error("aborted endpoint not refused");
	a_armed_ack: assert property (s_dev_start ##0 armed[DEV_TXN_EP] && !mask[DEV_TXN_EP] |=> DEV_RESP_CODE == 2'h0)
		else $error("armed endpoint not accepted");
	a_req_pulse: assert property (HOST_TXN_REQ |=> !HOST_TXN_REQ)
		else $error("launch longer than one cycle");
	a_busy_hold: assert property (busy && !HOST_TXN_DONE |=> !HOST_TXN_REQ)
		else $error("launch while busy");
	a_sw_launch: assert property (p_sw_launch)
		else $error("software transfer not launched");
	a_poll_bound: assert property (quiet < lim)
		else $error("interrupt poll overdue");
	a_fetch_single: assert property (!dbl || HOST_TXN_INTR |-> !HOST_FETCH_HALF)
		else $error("fetch used second half");
	a_sel_cause: assert property ($changed(HOST_BUF_SEL) |-> $past(HOST_TXN_DONE) && $past(dbl) && !$past(HOST_TXN_INTR))
		else $error("selector moved without cause");
	a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
		else $error("read data outside its cycle");
endmodule

bind ep_ctl ep_ctl_assertions ep_ctl_assertions_inst (.REF_CLK, .RST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
	.REG_RDATA, .DEV_TXN_START, .DEV_TXN_EP, .DEV_TXN_DONE, .DEV_RESP_VALID, .DEV_RESP_CODE, .HOST_TXN_REQ,
	.HOST_TXN_EP, .HOST_TXN_INTR, .HOST_BUF_SEL, .HOST_FETCH_HALF, .HOST_TXN_DONE);
`default_nettype wire

// File: sim/usb_peer_model.sv
// Link peer: opens device-role transactions, completes host transfers.
// Assumes the bench sets lat and calls dev_txn.
`timescale 1ns/1ps
`default_nettype none
module usb_peer_model (
	// Clock and reset
	input wire logic	clk,
	input wire logic	rst,
	// Device-role link
	output var logic	start,
	output var logic [3:0]	ep,
	output var logic	done,
	// Host-role link
	input wire logic	req,
	output var logic	hdone
);
	int	lat = 1;
	int	cnt;

	initial begin
		start = 1'h0;
		ep = 4'h0;
		done = 1'h0;
	end

	// Endpoint lines scrambled once the start is gone
	task automatic dev_txn(input logic [3:0] e, input bit fin);
		@(posedge clk);
		start <= 1'h1;
		ep <= e;
		@(posedge clk);
		start <= 1'h0;
		ep <= ~e;
		if (fin) begin
			@(posedge clk);
			done <= 1'h1;
			@(posedge clk);
			done <= 1'h0;
		end
	endtask

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 0;
			hdone <= 1'h0;
		end else begin
			hdone <= !req && cnt == 1;
			cnt <= req ? lat : (cnt > 0 ? cnt - 1 : 0);
		end
	end
endmodule
`default_nettype wire

// File: sim/tb_ep_ctl.sv
// Self-checking bench for ep_ctl.
// Assumes the peer model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module tb_ep_ctl;
	logic		REF_CLK = 1'h0;
	logic		RST = 1'h1;
	logic [7:0]	REG_ADDR = 8'h0;
	logic [31:0]	REG_WDATA = 32'h0;
	logic		REG_WR = 1'h0;
	logic		REG_RD = 1'h0;
	logic [31:0]	REG_RDATA;
	logic		IRQ, DEV_TXN_START, DEV_TXN_DONE, DEV_RESP_VALID, HOST_TXN_REQ, HOST_TXN_INTR;
	logic		HOST_BUF_SEL, HOST_FETCH_HALF, HOST_TXN_DONE, rd_seen;
	logic [3:0]	DEV_TXN_EP, HOST_TXN_EP, ea, eb;
	logic [1:0]	DEV_RESP_CODE;
	logic [31:0]	q_rd[$];
	logic [1:0]	q_resp[$];
	logic [4:0]	q_req[$];
	int		fails = 0;
	int		check_count = 0;
	int		seed = 3;

	ep_ctl ep_ctl_inst (.REF_CLK, .RST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .IRQ, .DEV_TXN_START,
		.DEV_TXN_EP, .DEV_TXN_DONE, .DEV_RESP_VALID, .DEV_RESP_CODE, .HOST_TXN_REQ, .HOST_TXN_EP, .HOST_TXN_INTR,
		.HOST_BUF_SEL, .HOST_FETCH_HALF, .HOST_TXN_DONE);
	usb_peer_model usb_peer_model_inst (.clk(REF_CLK), .rst(RST), .start(DEV_TXN_START), .ep(DEV_TXN_EP),
		.done(DEV_TXN_DONE), .req(HOST_TXN_REQ), .hdone(HOST_TXN_DONE));

	always #2 REF_CLK = ~REF_CLK;

	// ****************
	// Tasks
	// ****************
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge REF_CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'h1;
		@(posedge REF_CLK);
		REG_WR <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		q_rd.push_back(e);
		@(posedge REF_CLK);
		REG_ADDR <= a;
		REG_RD <= 1'h1;
		@(posedge REF_CLK);
		REG_RD <= 1'h0;
	endtask
	task automatic host(input logic [7:0] a, input logic [31:0] d, input logic [4:0] e);
		int n;
		q_req.push_back(e);
		wr(a, d);
		for (n = 0; n < 2000; n++) begin
			@(posedge REF_CLK);
			if (HOST_TXN_DONE === 1'h1) break;
		end
		if (n == 2000) chk("host done", 32'h1, 32'h0);
		@(posedge REF_CLK);
	endtask
	task automatic print_verdict();
		if (fails == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ****************
	// Result watcher
	// ****************
	always @(posedge REF_CLK) begin
		rd_seen <= REG_RD;
		if (RST === 1'h0) begin
			if (rd_seen === 1'h1) chk("rdata", q_rd.size() ? q_rd.pop_front() : 'x, REG_RDATA);
			if (DEV_RESP_VALID !== 1'h0) chk("resp", q_resp.size() ? q_resp.pop_front() : 'x, DEV_RESP_CODE);
			if (HOST_TXN_REQ !== 1'h0) chk("req", q_req.size() ? q_req.pop_front() : 'x, {HOST_TXN_INTR, HOST_TXN_EP});
		end
	end

	initial begin
		#200000;
		fails++;
		print_verdict();
	end

	initial begin
		repeat (6) @(posedge REF_CLK);
		RST <= 1'h0;
		rd(ep_ctl_pkg::OFS_CTRL, 32'h0);
		rd(8'h30, 32'h0);
		rd(ep_ctl_pkg::OFS_IRQ_CLR, 32'h0);
		wr(ep_ctl_pkg::OFS_IRQ_EN, 32'hF);
		ea = 4'($random(seed));
		eb = ea ^ 4'h5;
		wr(ep_ctl_pkg::OFS_ARM, 32'h1 << ea);
		q_resp.push_back(ep_ctl_pkg::RESP_ACK);
		usb_peer_model_inst.dev_txn(ea, 1'h1);
		rd(ep_ctl_pkg::OFS_ARM, 32'h0);
		rd(ep_ctl_pkg::OFS_IRQ_STAT, 32'h2);
		wr(ep_ctl_pkg::OFS_ARM, (32'h1 << ea) | (32'h1 << eb));
		wr(ep_ctl_pkg::OFS_ABORT, 32'h1 << eb);
		rd(ep_ctl_pkg::OFS_ARM, 32'h1 << ea);
		q_resp.push_back(ep_ctl_pkg::RESP_NAK);
		usb_peer_model_inst.dev_txn(eb, 1'h0);
		q_resp.push_back(ep_ctl_pkg::RESP_ACK);
		usb_peer_model_inst.dev_txn(ea, 1'h1);
		rd(ep_ctl_pkg::OFS_ABORT_HIT, 32'h1 << eb);
		rd(ep_ctl_pkg::OFS_IRQ_STAT, 32'h3);
		wr(ep_ctl_pkg::OFS_IRQ_EN, 32'h0);
		@(negedge REF_CLK);
		chk("irq masked", 32'h0, IRQ);
		wr(ep_ctl_pkg::OFS_IRQ_EN, 32'hF);
		@(negedge REF_CLK);
		chk("irq raised", 32'h1, IRQ);
		wr(ep_ctl_pkg::OFS_IRQ_CLR, 32'hF);
		@(negedge REF_CLK);
		chk("irq cleared", 32'h0, IRQ);
		wr(ep_ctl_pkg::OFS_ABORT, 32'h0);
		wr(ep_ctl_pkg::OFS_CTRL, 32'h3);
		host(ep_ctl_pkg::OFS_START, 32'h2, 5'h02);
		rd(ep_ctl_pkg::OFS_PENDING, 32'h5);
		usb_peer_model_inst.lat = 20;
		host(ep_ctl_pkg::OFS_START, 32'h9, 5'h09);
		rd(ep_ctl_pkg::OFS_PENDING, 32'h3);
		host(ep_ctl_pkg::OFS_START, 32'h4, 5'h04);
		@(negedge REF_CLK);
		chk("fetch half dbl", 32'h1, HOST_FETCH_HALF);
		wr(ep_ctl_pkg::OFS_PENDING, 32'h3);
		wr(ep_ctl_pkg::OFS_CTRL, 32'h1);
		host(ep_ctl_pkg::OFS_INT_CFG, 32'h0002_0107, 5'h17);
		wr(ep_ctl_pkg::OFS_INT_CFG, 32'h0);
		rd(ep_ctl_pkg::OFS_PENDING, 32'h6);
		@(negedge REF_CLK);
		chk("fetch half", 32'h0, HOST_FETCH_HALF);
		rd(ep_ctl_pkg::OFS_IRQ_STAT, 32'hC);
		host(ep_ctl_pkg::OFS_START, 32'h4, 5'h04);
		@(negedge REF_CLK);
		chk("selector", 32'h1, HOST_BUF_SEL);
		wr(ep_ctl_pkg::OFS_CTRL, 32'h0);
		wr(ep_ctl_pkg::OFS_START, 32'h3);
		repeat (8) @(posedge REF_CLK);
		RST <= 1'h1;
		repeat (2) @(posedge REF_CLK);
		RST <= 1'h0;
		rd(ep_ctl_pkg::OFS_PENDING, 32'h0);
		repeat (3) @(posedge REF_CLK);
		chk("leftover notes", 32'h0, q_rd.size() + q_resp.size() + q_req.size());
		print_verdict();
	end
endmodule
`default_nettype wire
